/* File: core/pwr_clk_pkg.sv */
/*
 * Package for the power and clock control block: register offsets, bit
 * positions, reset values, frequency-select codes and timing constants.
 * Assumes a single 50 MHz clock domain.
 */
package pwr_clk_pkg;

    // ==========================================================
    // Register map: word indices, byte address is four times the index
    // ==========================================================
    localparam logic [7:0] power_control_addr       = 8'h87;
    localparam logic [7:0] clock_synth_control_addr = 8'hf9;
    localparam logic [7:0] status_addr              = 8'h40;
    localparam int         word_index_msb           = 9;
    localparam int         word_index_lsb           = 2;

    localparam logic [7:0] power_control_reset       = 8'h00;
    localparam logic [7:0] clock_synth_control_reset = 8'h0d;

    // ==========================================================
    // Power control bits
    // ==========================================================
    localparam int baud_double_bit          = 7;
    localparam int aux_memory_disable_bit   = 6;
    localparam int emission_quiet_bit       = 5;
    localparam int watchdog_load_permit_bit = 4;
    localparam int user_flag_hi_bit         = 3;
    localparam int user_flag_lo_bit         = 2;
    localparam int deep_sleep_request_bit   = 1;
    localparam int halt_cpu_request_bit     = 0;

    // ==========================================================
    // Clock synth control bits
    // ==========================================================
    localparam int keep_slow_osc_bit   = 7;
    localparam int tick_irq_enable_bit = 6;
    localparam int tick_irq_flag_bit   = 5;
    localparam int freq_select_hi_msb         = 4;
    localparam int freq_select_hi_lsb         = 2;
    localparam int freq_select_lo_msb         = 1;

    // Legal frequency-select codes
    localparam logic [4:0] freq_select_3m93  = 5'h13;
    localparam logic [4:0] freq_select_7m86  = 5'h0f;
    localparam logic [4:0] freq_select_15m73 = 5'h0b;
    localparam logic [4:0] freq_select_4m72  = 5'h12;
    localparam logic [4:0] freq_select_9m44  = 5'h0e;
    localparam logic [4:0] freq_select_5m51  = 5'h11;
    localparam logic [4:0] freq_select_11m01 = 5'h0d;
    localparam logic [4:0] freq_select_6m29  = 5'h10;
    localparam logic [4:0] freq_select_12m58 = 5'h0c;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int clk_mhz          = 50;
    localparam int lock_time_ms     = 10;
    localparam int lock_cycles      = lock_time_ms * 1000 * clk_mhz;
    localparam int divider_settle_us = 1;
    localparam int divider_settle_cycles = divider_settle_us * clk_mhz;

    // Clock switch sequencer states
    typedef enum logic [1:0]
    {
        switch_idle   = 2'b00,
        switch_gate   = 2'b01,
        switch_settle = 2'b10,
        switch_lock   = 2'b11
    } switch_state_t;

endpackage : pwr_clk_pkg

/* File: core/power_and_clock_control.sv */
/*
 * Power-mode and system-clock control with an AHB-Lite register slave.
 * Assumes the CPU core, watchdog, seconds timer and PLL analog sit outside
 * and exchange one-cycle event pulses and levels on the ports.
 */
// The AHB-Lite register port was decided locally.
// Operation
// R01 - Power control resets zero, whole byte access
// R02 - Bit 7 doubles serial port baud
// R03 - Bit 6 disables auxiliary RAM
// R04 - Bit 5 silences address latch strobe
// R05 - Load permit cleared on watchdog load
// R06 - Bits 3, 2 plain user flags
// R07 - Deep sleep settable only with strap high
// R08 - Bit 0 requests idle mode
// R09 - Source select one: crystal, slow osc halted
// R10 - Source select zero: slow osc and PLL
// R11 - Slow osc tri-stated in three cases
// R12 - Low select bits set PLL; 10 ms lock
// R13 - Lowering: high bits first, then low
// R14 - Raising: low bits, wait, then high
// R15 - High bits only change in 1 us
// R16 - Reset or watchdog overflow loads 0DH
// R17 - Bit 7 keeps slow osc in sleep
// R18 - Tick irq needs enable and ext irq one
// R19 - Tick flag set by hardware or software
// R20 - Nine codes map to clock frequencies
// R21 - Other select codes reserved
// R22 - Enabled interrupt clears idle request
// R23 - No deep sleep while watchdog enabled
// R24 - Glitch-free switch on selection change
`timescale 1ns/1ns

module power_and_clock_control
#(
    parameter int lock_cycles = pwr_clk_pkg::lock_cycles
)
(
    input  wire logic        clk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Surroundings
    input  wire logic        watchdog_strap_input,
    input  wire logic        watchdog_enabled,
    input  wire logic        watchdog_overflow,
    input  wire logic        watchdog_counter_load,
    input  wire logic        osc_source_select,
    input  wire logic        seconds_overflow,
    input  wire logic        ext_irq_one_enable,
    input  wire logic        idle_wake_irq,
    // Controls toward the rest of the chip
    output logic             baud_double,
    output logic             aux_memory_disable,
    output logic             emission_quiet,
    output logic             watchdog_load_permit,
    output logic             halt_cpu_request,
    output logic             deep_sleep_request,
    output logic             hf_osc_enable,
    output logic             slow_osc_enable,
    output logic             slow_xtal_input_pulldown,
    output logic [1:0]       pll_current_osc,
    output logic [4:0]       freq_select,
    output logic             sys_clk_gate,
    output logic             pll_locked,
    output logic             tick_irq
);

    // ==========================================================
    // Register state
    // ==========================================================
    logic [7:0]                 power_control;
    logic [7:0]                 clock_synth_control;
    logic                       req_write;
    logic [7:0]                 req_addr;
    logic [7:0]                 rd_index;
    logic                       wr_power;
    logic                       wr_clock;
    logic [7:0]                 wdata;
    pwr_clk_pkg::switch_state_t state;
    logic [31:0]                timer;
    logic                       synth_reset;
    logic                       busy;

    // Watchdog overflow reloads the synth register like a pin reset
    assign synth_reset = watchdog_overflow; // R16
    assign wdata       = hwdata[7:0];
    // One register per aligned word; the low address bits are ignored
    assign rd_index    = haddr[pwr_clk_pkg::word_index_msb:pwr_clk_pkg::word_index_lsb];
    assign wr_power    = req_write && (req_addr == pwr_clk_pkg::power_control_addr);
    assign wr_clock    = req_write && (req_addr == pwr_clk_pkg::clock_synth_control_addr);
    assign busy        = (state != pwr_clk_pkg::switch_idle);

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    // ==========================================================
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            req_write <= 1'b0;
            req_addr  <= 8'h00;
        end
        else if (hready)
        begin
            req_write <= hsel && htrans[1] && hwrite;
            req_addr  <= rd_index;
        end
        else
        begin
            req_write <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data registered in the address phase; reads only whole byte
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            if (rd_index == pwr_clk_pkg::power_control_addr)
            begin
                hrdata <= {24'h00_0000, power_control}; // R01
            end
            else if (rd_index == pwr_clk_pkg::clock_synth_control_addr)
            begin
                hrdata <= {24'h00_0000, clock_synth_control};
            end
            else if (rd_index == pwr_clk_pkg::status_addr)
            begin
                hrdata <= {29'h0000_0000, pll_locked, sys_clk_gate, busy};
            end
            else
            begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Power control register
    // ==========================================================
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            power_control <= pwr_clk_pkg::power_control_reset; // R01
        end
        else
        begin
            if (wr_power)
            begin
                // Bits 7..2 take the written value; bit 4 is also cleared by watchdog load
                power_control[pwr_clk_pkg::baud_double_bit:pwr_clk_pkg::user_flag_lo_bit] <=
                    wdata[pwr_clk_pkg::baud_double_bit:pwr_clk_pkg::user_flag_lo_bit]; // R02 R03 R04 R05 R06
                power_control[pwr_clk_pkg::halt_cpu_request_bit] <=
                    wdata[pwr_clk_pkg::halt_cpu_request_bit]; // R08
                // A refused deep-sleep write stores zero, whatever the bit held
                power_control[pwr_clk_pkg::deep_sleep_request_bit] <=
                    wdata[pwr_clk_pkg::deep_sleep_request_bit]
                    && watchdog_strap_input && !watchdog_enabled; // R07 R23
            end
            // Hardware clears take effect over a same-cycle write
            if (watchdog_counter_load)
            begin
                power_control[pwr_clk_pkg::watchdog_load_permit_bit] <= 1'b0; // R05
            end
            if (idle_wake_irq)
            begin
                power_control[pwr_clk_pkg::halt_cpu_request_bit] <= 1'b0; // R22
            end
        end
    end

    // ==========================================================
    // Clock synth control register
    // ==========================================================
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            clock_synth_control <= pwr_clk_pkg::clock_synth_control_reset; // R16
        end
        else if (synth_reset)
        begin
            clock_synth_control <= pwr_clk_pkg::clock_synth_control_reset; // R16
        end
        else
        begin
            if (wr_clock)
            begin
                clock_synth_control <= wdata; // R17 R18 R13 R14 R21
            end
            // Overflow wins over a software clear in the same cycle
            if (seconds_overflow)
            begin
                clock_synth_control[pwr_clk_pkg::tick_irq_flag_bit] <= 1'b1; // R19
            end
        end
    end

    // ==========================================================
    // Clock switch sequencer: gate the clock, then settle or wait for lock
    // ==========================================================
    // Applied select only moves while the system clock is gated, so the
    // divider never emits a truncated pulse.
    logic [4:0] applied_select;
    logic [4:0] target_select;
    assign target_select = clock_synth_control[pwr_clk_pkg::freq_select_hi_msb:0];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state          <= pwr_clk_pkg::switch_idle;
            timer          <= 32'h0000_0000;
            applied_select <= pwr_clk_pkg::clock_synth_control_reset[4:0];
            pll_locked     <= 1'b1;
            sys_clk_gate   <= 1'b1;
        end
        else
        begin
            case (state)
                pwr_clk_pkg::switch_idle:
                begin
                    if (target_select != applied_select)
                    begin
                        sys_clk_gate <= 1'b0; // R24
                        state        <= pwr_clk_pkg::switch_gate;
                    end
                end
                pwr_clk_pkg::switch_gate:
                begin
                    if (target_select[pwr_clk_pkg::freq_select_lo_msb:0]
                        != applied_select[pwr_clk_pkg::freq_select_lo_msb:0])
                    begin
                        pll_locked <= 1'b0;
                        timer      <= 32'(lock_cycles); // R12
                        state      <= pwr_clk_pkg::switch_lock;
                    end
                    else
                    begin
                        timer <= 32'(pwr_clk_pkg::divider_settle_cycles); // R15
                        state <= pwr_clk_pkg::switch_settle;
                    end
                    applied_select <= target_select; // R20
                end
                pwr_clk_pkg::switch_settle,
                pwr_clk_pkg::switch_lock:
                begin
                    if (timer <= 32'h0000_0001)
                    begin
                        pll_locked   <= 1'b1;
                        sys_clk_gate <= 1'b1; // R24
                        state        <= pwr_clk_pkg::switch_idle;
                    end
                    else
                    begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
                default:
                begin
                    state <= pwr_clk_pkg::switch_idle;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered control outputs
    // ==========================================================
    // Power control mirrors, one cycle behind the register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            baud_double              <= 1'b0;
            aux_memory_disable       <= 1'b0;
            emission_quiet           <= 1'b0;
            watchdog_load_permit     <= 1'b0;
            halt_cpu_request         <= 1'b0;
            deep_sleep_request       <= 1'b0;
        end
        else
        begin
            baud_double          <= power_control[pwr_clk_pkg::baud_double_bit]; // R02
            aux_memory_disable   <= power_control[pwr_clk_pkg::aux_memory_disable_bit]; // R03
            emission_quiet       <= power_control[pwr_clk_pkg::emission_quiet_bit]; // R04
            watchdog_load_permit <= power_control[pwr_clk_pkg::watchdog_load_permit_bit]; // R05
            halt_cpu_request     <= power_control[pwr_clk_pkg::halt_cpu_request_bit]; // R08
            deep_sleep_request   <= power_control[pwr_clk_pkg::deep_sleep_request_bit]; // R07
        end
    end

    // ==========================================================
    // Oscillator controls
    // ==========================================================
    // The slow input is pulled low whenever its oscillator is off, reset included
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hf_osc_enable            <= 1'b0;
            slow_osc_enable          <= 1'b0;
            slow_xtal_input_pulldown <= 1'b1; // R11
        end
        else
        begin
            hf_osc_enable        <= osc_source_select
                                    && !power_control[pwr_clk_pkg::deep_sleep_request_bit]; // R09
            slow_osc_enable      <= !osc_source_select
                                    && (!power_control[pwr_clk_pkg::deep_sleep_request_bit]
                                        || clock_synth_control[pwr_clk_pkg::keep_slow_osc_bit]); // R10 R17
            slow_xtal_input_pulldown <= osc_source_select
                                    || (power_control[pwr_clk_pkg::deep_sleep_request_bit]
                                        && !clock_synth_control[pwr_clk_pkg::keep_slow_osc_bit]); // R11
        end
    end

    // Select mirrors follow the applied code, never the raw register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pll_current_osc          <= 2'h0;
            freq_select              <= 5'h00;
        end
        else
        begin
            pll_current_osc      <= applied_select[pwr_clk_pkg::freq_select_lo_msb:0]; // R12
            freq_select          <= applied_select; // R20
        end
    end

    // ==========================================================
    // Seconds interrupt
    // ==========================================================
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tick_irq                 <= 1'b0;
        end
        else
        begin
            tick_irq             <= clock_synth_control[pwr_clk_pkg::tick_irq_flag_bit]
                                    && clock_synth_control[pwr_clk_pkg::tick_irq_enable_bit]
                                    && ext_irq_one_enable; // R18
        end
    end

endmodule : power_and_clock_control

/* File: verification/pwr_clk_props.sv */
/* Checker for power_and_clock_control: port-level relations of the
   oscillator controls, clock switching and hardware clears.
   Assumes binding to every instance of the block, one clock domain. */
`timescale 1ns/1ns
module pwr_clk_props
#(
    parameter int lock_cycles = 20
)
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       hf_osc_enable,
    input wire logic       slow_osc_enable,
    input wire logic       slow_xtal_input_pulldown,
    input wire logic       deep_sleep_request,
    input wire logic       watchdog_strap_input,
    input wire logic       watchdog_enabled,
    input wire logic       tick_irq,
    input wire logic       ext_irq_one_enable,
    input wire logic       pll_locked,
    input wire logic       sys_clk_gate,
    input wire logic [4:0] freq_select,
    input wire logic       watchdog_counter_load,
    input wire logic       watchdog_load_permit,
    input wire logic       idle_wake_irq,
    input wire logic       halt_cpu_request,
    input wire logic       watchdog_overflow
);
    // Longest gated stretch: full lock wait plus margin
    localparam int gate_max = lock_cycles + 60;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Oscillators
    // ==========================================================
    a_osc_exclusive: assert property (!(hf_osc_enable && slow_osc_enable))
        else $error("both oscillators enabled");
    a_pulldown_match: assert property (slow_xtal_input_pulldown == !slow_osc_enable)
        else $error("slow input pull-down disagrees with oscillator enable");
    a_sleep_refused: assert property ($rose(deep_sleep_request) |->
        $past(watchdog_strap_input, 2) && !$past(watchdog_enabled, 2))
        else $error("deep sleep entered while not permitted");
    // ==========================================================
    // Clock switching
    // ==========================================================
    a_lock_gated: assert property (!pll_locked |-> !sys_clk_gate)
        else $error("clock running while pll not locked");
    a_gate_bounded: assert property ($fell(sys_clk_gate) |-> ##[1:gate_max] sys_clk_gate)
        else $error("clock gated too long");
    a_freq_gated: assert property ($changed(freq_select) && !$past(reset, 2) |->
        (!sys_clk_gate || !$past(sys_clk_gate)))
        else $error("frequency changed while clock running");
    // ==========================================================
    // Hardware clears and interrupt
    // ==========================================================
    a_tick_gated: assert property (tick_irq |-> $past(ext_irq_one_enable))
        else $error("tick interrupt without external enable");
    a_permit_clear: assert property (watchdog_counter_load |-> ##2 !watchdog_load_permit)
        else $error("load permit not cleared");
    a_idle_clear: assert property (idle_wake_irq |-> ##2 !halt_cpu_request)
        else $error("idle request not cleared");
    a_reload_quiet: assert property (watchdog_overflow |-> ##2 !tick_irq)
        else $error("tick interrupt survives reload");
endmodule : pwr_clk_props

bind power_and_clock_control pwr_clk_props #(.lock_cycles(lock_cycles)) u_props (.*);

/* File: verification/power_and_clock_control_tb_top.sv */
/* Testbench for power_and_clock_control: AHB-Lite master tasks, reads
   checked through a queue of expected words, direct checks of controls.
   Assumes the package and design are compiled first. */
`timescale 1ns/1ns
module power_and_clock_control_tb_top;
    localparam int lock = 120;
    logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        watchdog_strap_input = 1'b0, watchdog_enabled = 1'b0;
    logic        osc_source_select = 1'b1, ext_irq_one_enable = 1'b0;
    logic [3:0]  ev = 4'h0;
    wire logic   watchdog_overflow = ev[0], watchdog_counter_load = ev[1];
    wire logic   seconds_overflow = ev[2], idle_wake_irq = ev[3];
    wire logic   hready, hreadyout, hresp, baud_double, aux_memory_disable, emission_quiet;
    wire logic   watchdog_load_permit, halt_cpu_request, deep_sleep_request, hf_osc_enable;
    wire logic   slow_osc_enable, slow_xtal_input_pulldown, sys_clk_gate, pll_locked, tick_irq;
    wire logic [31:0] hrdata;
    wire logic [1:0]  pll_current_osc;
    wire logic [4:0]  freq_select;
    logic [31:0] exp_q[$];
    logic [4:0]  cur = 5'h0d;
    // Each step moves one field group only, and every step is a legal code
    logic [4:0]  codes [9] = '{5'h0e, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h13, 5'h0f, 5'h0b, 5'h0f};
    int          error_cnt = 0, comparisons = 0;

    assign hready = hreadyout;
    always #10 clk = ~clk;
    power_and_clock_control #(.lock_cycles(lock)) u_dut (.*);

    // ==========================================================
    // Checks and bus tasks
    // ==========================================================
    task automatic tally_and_finish;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_data

    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            tally_and_finish;
        end
    endtask : wait_ready

    // a is a word index; a read queues its expected word for the monitor
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, a, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready;
        htrans   <= 2'h0;
        hwdata   <= d;
        rd_phase <= !w;
        if (!w)
            exp_q.push_back(d);
        wait_ready;
        rd_phase <= 1'b0;
    endtask : bus

    always @(posedge clk)
        if (rd_phase === 1'b1 && hready === 1'b1 && exp_q.size() > 0)
            check_data(hrdata, exp_q.pop_front());

    // Outputs follow the register one cycle later, so wait two edges
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev <= 4'h0;
    endtask : pulse

    task automatic chk_power(input logic [7:0] v);
        check_data(baud_double, v[7]);
        check_data(aux_memory_disable, v[6]);
        check_data(emission_quiet, v[5]);
        check_data(watchdog_load_permit, v[4]);
        check_data(deep_sleep_request, v[1]);
        check_data(halt_cpu_request, v[0]);
    endtask : chk_power

    task automatic switch_to(input logic [4:0] code);
        int n, low, exp;
        exp = (code[1:0] != cur[1:0]) ? lock : pwr_clk_pkg::divider_settle_cycles;
        bus(1'b1, 8'hf9, {27'h0, code});
        for (n = 0; n < 10 && sys_clk_gate !== 1'b0; n++)
            @(posedge clk);
        for (low = 0; low < 400 && sys_clk_gate !== 1'b1; low++)
            @(posedge clk);
        check_data(low >= exp && low <= exp + 4, 1'b1);
        #1;
        check_data(freq_select, code);
        check_data(pll_current_osc, code[1:0]);
        cur = code;
    endtask : switch_to

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        int i;
        logic [7:0] d;
        void'($urandom(32'hd599d3f0));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 8'h87, 32'h00);
        bus(1'b0, 8'hf9, 32'h0d);
        bus(1'b0, 8'h10, 32'h00);
        check_data(freq_select, 5'h0d);
        for (i = 0; i < 8; i++)
        begin
            bus(1'b1, 8'h87, 32'h1 << i);
            settle;
            chk_power((i == 1) ? 8'h00 : 8'h01 << i);
            bus(1'b0, 8'h87, (i == 1) ? 32'h0 : 32'h1 << i);
        end
        repeat (4)
        begin
            d = 8'($urandom()) & 8'hfd;
            bus(1'b1, 8'h87, {24'h0, d});
            settle;
            chk_power(d);
            bus(1'b0, 8'h87, {24'h0, d});
        end
        bus(1'b1, 8'h87, 32'h00);
        watchdog_strap_input <= 1'b1;
        watchdog_enabled     <= 1'b1;
        bus(1'b1, 8'h87, 32'h02);
        bus(1'b0, 8'h87, 32'h00);
        watchdog_enabled <= 1'b0;
        bus(1'b1, 8'h87, 32'h02);
        settle;
        chk_power(8'h02);
        check_data(hf_osc_enable, 1'b0);
        @(posedge clk);
        osc_source_select <= 1'b0;
        settle;
        check_data(slow_xtal_input_pulldown, 1'b1);
        bus(1'b1, 8'hf9, 32'h8d);
        settle;
        check_data(slow_osc_enable, 1'b1);
        bus(1'b1, 8'h87, 32'h00);
        osc_source_select <= 1'b1;
        settle;
        check_data(hf_osc_enable, 1'b1);
        check_data(slow_xtal_input_pulldown, 1'b1);
        bus(1'b1, 8'h87, 32'h10);
        pulse(1);
        settle;
        bus(1'b0, 8'h87, 32'h00);
        bus(1'b1, 8'h87, 32'h01);
        pulse(3);
        settle;
        bus(1'b0, 8'h87, 32'h00);
        ext_irq_one_enable <= 1'b1;
        bus(1'b1, 8'hf9, 32'h4d);
        pulse(2);
        settle;
        check_data(tick_irq, 1'b1);
        bus(1'b0, 8'hf9, 32'h6d);
        bus(1'b1, 8'hf9, 32'h4d);
        settle;
        check_data(tick_irq, 1'b0);
        bus(1'b1, 8'hf9, 32'h6d);
        settle;
        check_data(tick_irq, 1'b1);
        @(posedge clk);
        ext_irq_one_enable <= 1'b0;
        settle;
        check_data(tick_irq, 1'b0);
        @(posedge clk);
        ext_irq_one_enable <= 1'b1;
        pulse(0);
        settle;
        bus(1'b0, 8'hf9, 32'h0d);
        osc_source_select <= 1'b0;
        settle;
        check_data(slow_osc_enable, 1'b1);
        for (i = 0; i < 9; i++)
            switch_to(codes[i]);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 8'hf9, 32'h0d);
        bus(1'b0, 8'h87, 32'h00);
        settle;
        tally_and_finish;
    end

    initial
    begin
        #1000000;
        error_cnt++;
        tally_and_finish;
    end
endmodule : power_and_clock_control_tb_top
